// file: bench/adc_calibration_register_access_test.sv
// testbench: host and device ends joined, driven from the host user side
`timescale 1ns/1ns
module adc_calibration_register_access_test;
  import cal_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  op_type cmd_op = OP_NONE;
  logic [15:0] cmd_data = 16'h0000;
  logic conv_pulse = 1'b0;
  logic [13:0] offset_measured = 14'h1f00;
  logic [13:0] gain_measured = 14'h2100;
  logic [13:0] dac_measured = 14'h0abc;
  logic cmd_ready, rsp_valid, cal_kind, conv_start;
  logic [15:0] rsp_data;
  logic [13:0] offset_trim, gain_trim;
  logic [15:0] exp_word [10];
  int err_total = 0;
  int tests_run = 0;
  int conv_count = 0;
  cal_if cal_if_i ();
  cal_device #(.CAL_STEP(2)) cal_device_i (.clk(clk), .rst(rst), .link(cal_if_i.device),
    .offset_measured(offset_measured), .gain_measured(gain_measured), .dac_measured(dac_measured),
    .conv_start(conv_start), .cal_kind(cal_kind), .offset_trim(offset_trim), .gain_trim(gain_trim));
  cal_host cal_host_i (.clk(clk), .rst(rst), .link(cal_if_i.host), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .conv_pulse(conv_pulse), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  cal_chk cal_chk_i (.clk(clk), .rst(rst), .master_clock_input(cal_if_i.master_clock_input), .req(cal_if_i.req),
    .op(cal_if_i.op), .wdata(cal_if_i.wdata), .ack(cal_if_i.ack), .rdata(cal_if_i.rdata), .busy(cal_if_i.busy));
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (conv_start === 1'b1) conv_count++;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one host request; reads are compared, the response comes three cycles after the request
  task automatic access(input op_type op, input logic [15:0] data, input logic [15:0] exp);
    logic [15:0] got;
    int n;
    n = 0;
    got = 16'hxxxx;
    @(posedge clk);
    while (cmd_ready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    if (cmd_ready !== 1'b1)
    begin
      err_total++;
      $display("wrong value at %0t: host never ready", $time);
    end
    cmd_op <= op;
    cmd_data <= data;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      if (rsp_valid === 1'b1)
        got = rsp_data;
    end
    if (op == OP_READ)
      check(got, exp);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    #(20000 * 4);
    err_total++;
    end_of_test();
  end
  initial
  begin
    int n;
    n = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    access(OP_CTRL, 16'h0008, 16'h0000);
    for (int i = 0; i < 10; i++) access(OP_READ, 16'h0000, 16'h2000);
    $display("test reset values done");
    access(OP_CTRL, 16'h0000, 16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      exp_word[i] = {2'b00, 14'h0123 + 14'(i * 273)};
      access(OP_WRITE, {2'b11, exp_word[i][13:0]}, 16'h0000);
    end
    check({2'b00, gain_trim}, exp_word[0]);
    check({2'b00, offset_trim}, exp_word[1]);
    access(OP_CTRL, 16'h0008, 16'h0000);
    for (int i = 0; i < 11; i++) access(OP_READ, 16'h0000, exp_word[i % 10]);
    $display("test write and read back done");
    for (int t = 1; t < 4; t++)
    begin
      access(OP_CTRL, 16'h0008 | 16'(t), 16'h0000);
      access(OP_READ, 16'h0000, exp_word[t == 2]);
      access(OP_READ, 16'h0000, exp_word[t != 3]);
    end
    access(OP_CTRL, 16'h0008, 16'h0000);
    access(OP_READ, 16'h0000, exp_word[0]);
    access(OP_CTRL, 16'h0008, 16'h0000);
    access(OP_READ, 16'h0000, exp_word[0]);
    $display("test subsets and abort done");
    access(OP_CTRL, 16'h0048, 16'h0000);
    access(OP_READ, 16'h0000, exp_word[0]);
    while (cal_if_i.busy !== 1'b0 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check({15'h0000, cal_if_i.busy}, 16'h0000);
    access(OP_CTRL, 16'h0008, 16'h0000);
    access(OP_READ, 16'h0000, {2'b00, gain_measured});
    access(OP_READ, 16'h0000, {2'b00, offset_measured});
    for (int i = 0; i < 8; i++) access(OP_READ, 16'h0000, {2'b00, dac_measured});
    $display("test calibration run done");
    access(OP_CTRL, 16'h0030, 16'h0000);
    check({15'h0000, cal_kind}, 16'h0001);
    @(posedge clk);
    conv_pulse <= 1'b1;
    @(posedge clk);
    conv_pulse <= 1'b0;
    repeat (6) @(posedge clk);
    check(16'(conv_count), 16'h0002);
    $display("test conversion start done");
    end_of_test();
  end
endmodule

// file: bench/cal_chk_sva.sv
// checker: timing relations on the host-device access channel
`timescale 1ns/1ns
module cal_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic master_clock_input,
  input wire logic req,
  input wire cal_pkg::op_type op,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic busy
);
  import cal_pkg::*;
  localparam int MCLK_HALF = MCLK_DIV;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_cal_go;
    req && op == OP_CTRL && wdata[POS_STCAL] && !busy;
  endsequence
  sequence s_read_go;
    req && op == OP_READ;
  endsequence
  property p_ack_next;
    req |=> ack;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_one_gap;
    req |=> !req;
  endproperty
  a_one_gap: assert property (p_one_gap) else $error("requests back to back");
  property p_rdata_cause;
    $changed(rdata) |-> ack && $past(req) && $past(op) == OP_READ;
  endproperty
  a_rdata_cause: assert property (p_rdata_cause) else $error("read word changed without a read");
  property p_zeros;
    s_read_go |=> rdata[15:14] == 2'b00;
  endproperty
  a_zeros: assert property (p_zeros) else $error("read word lacks leading zeros");
  property p_busy_rise;
    s_cal_go |=> busy;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("calibration did not start");
  property p_busy_end;
    $rose(busy) |-> ##[1:400] !busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("calibration run never ends");
  property p_busy_freeze;
    req && op == OP_READ && busy |=> $stable(rdata);
  endproperty
  a_busy_freeze: assert property (p_busy_freeze) else $error("read served during calibration");
  property p_write_keeps;
    req && op == OP_WRITE |=> $stable(rdata);
  endproperty
  a_write_keeps: assert property (p_write_keeps) else $error("write disturbed read word");
  // the divided clock must hold each level for more than eight system cycles
  property p_mclk;
    $changed(master_clock_input) |=> $stable(master_clock_input) [*8];
  endproperty
  a_mclk: assert property (p_mclk) else $error("master clock toggles too fast");
  // a stalled divider would satisfy the check above, so bound the half period too
  property p_mclk_period;
    $changed(master_clock_input) |-> ##[1:MCLK_HALF] $changed(master_clock_input);
  endproperty
  a_mclk_period: assert property (p_mclk_period) else $error("master clock stalled");
endmodule

// file: common/cal_if.sv
// interface: access channel between host and calibration register block
`timescale 1ns/1ns
interface cal_if;
  logic master_clock_input;
  logic conversion_trigger_n;
  logic req;
  cal_pkg::op_type op;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic busy;
  modport device (input master_clock_input, input conversion_trigger_n, input req, input op, input wdata,
                  output ack, output rdata, output busy);
  modport host (output master_clock_input, output conversion_trigger_n, output req, output op,
                output wdata, input ack, input rdata, input busy);
endinterface

// file: common/cal_pkg.sv
// package: calibration register access constants and types
package cal_pkg;
  localparam int WORD_W = 16;
  localparam int DATA_W = 14;
  localparam int NUM_DAC = 8;
  localparam int NUM_REGS = 10;
  localparam int PTR_W = 4;
  // pointer order: gain, offset, dac1..dac8
  localparam logic [3:0] IDX_GAIN = 4'h0;
  localparam logic [3:0] IDX_OFFSET = 4'h1;
  localparam logic [3:0] IDX_DAC0 = 4'h2;
  // control word field positions
  localparam int CTL_W = 8;
  localparam int POS_TGT_LO = 0;
  localparam int POS_TGT_HI = 1;
  localparam int POS_RDB_LO = 2;
  localparam int POS_RDB_HI = 3;
  localparam int POS_KIND = 4;
  localparam int POS_CONV = 5;
  localparam int POS_STCAL = 6;
  localparam logic [1:0] RDB_CAL = 2'b10;
  localparam logic [1:0] TGT_ALL = 2'b00;
  localparam logic [1:0] TGT_GAIN_OFS = 2'b01;
  localparam logic [1:0] TGT_OFS = 2'b10;
  localparam logic [1:0] TGT_GAIN = 2'b11;
  // reset values of trim words
  localparam logic [13:0] OFFSET_NOMINAL = 14'h2000;
  localparam logic [13:0] GAIN_NOMINAL = 14'h2000;
  localparam logic [13:0] DAC_NOMINAL = 14'h2000;
  // cycles taken by one calibration step inside the device
  localparam int CAL_STEP_CYCLES = 16;
  // master clock rate expected from the host (faster variant)
  localparam int MCLK_KHZ = 4000;
  localparam int SYS_MHZ = 250;
  localparam int MCLK_DIV = (SYS_MHZ * 1000) / (2 * MCLK_KHZ);
  // four-state base so the type can ride on wire ports
  typedef enum logic [1:0] {OP_NONE, OP_CTRL, OP_WRITE, OP_READ} op_type;
  typedef enum {CAL_IDLE, CAL_DAC, CAL_GAIN, CAL_OFFSET} cal_state_type;
endpackage

// file: verilog/cal_device.sv
// device end: calibration trim register bank with pointer access and self calibration
// Overview of operation
// RULE1 - ten trim registers, all host read/write
// RULE2 - calibration run updates registers by itself
// RULE3 - target select chooses ten, two, offset, gain
// RULE4 - same decoding for reads and writes
// RULE5 - host sets target select before writing
// RULE6 - readback select 10 routes trim words out
// RULE7 - pointer restarts on control write or end
// RULE8 - pointer starts at gain, offset when alone
// RULE9 - pointer advances after each access
// RULE10 - aborted sequence restarts on next control write
// RULE11 - read words carry two leading zeros
// RULE12 - mode 1 reads must finish whole sequence
// RULE13 - offset word: two zeros, fourteen bits
// RULE14 - offset settles near 0x2000 after calibration
// RULE15 - larger offset fixes negative input offset
// RULE16 - offset bits binary weighted, plus minus 5%
// RULE17 - gain word: two zeros, fourteen bits
// RULE18 - larger gain fixes smaller span, 0.975-1.025
// RULE19 - conversion starts by control write or pin
// RULE20 - host supplies 4 MHz master clock
// RULE21 - full calibration: dac, gain, then offset
// RULE22 - order gain, offset, dac one to eight
`timescale 1ns/1ns
module cal_device #(
  parameter int CAL_STEP = cal_pkg::CAL_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  cal_if.device link,
  input wire logic [13:0] offset_measured,
  input wire logic [13:0] gain_measured,
  input wire logic [13:0] dac_measured,
  output logic conv_start,
  output logic cal_kind,
  output logic [13:0] offset_trim,
  output logic [13:0] gain_trim
);
  import cal_pkg::*;

  logic [DATA_W-1:0] trim_r [NUM_REGS]; // RULE1
  logic [1:0] tgt_r;
  logic [1:0] rdb_r;
  logic kind_r;
  logic ack_r;
  logic [WORD_W-1:0] rdata_r;
  logic conv_r;
  logic trig_d_r;
  cal_state_type cal_st_r;
  logic [7:0] cal_cnt_r;
  logic [3:0] dac_idx_r;
  logic [PTR_W-1:0] ptr;
  logic last;
  logic ctrl_wr;
  logic cal_acc;
  logic step_done;

  assign ctrl_wr = link.req && link.op == OP_CTRL;
  // calibration access is ignored while a calibration run owns the bank
  assign cal_acc = link.req && (link.op == OP_WRITE || (link.op == OP_READ && rdb_r == RDB_CAL)) &&
                   cal_st_r == CAL_IDLE; // RULE4 RULE6
  assign step_done = cal_cnt_r == 8'(CAL_STEP - 1);

  // any control write restarts the pointer; this is also how an aborted sequence ends
  cal_ptr_seq u_ptr (
    .clk(clk),
    .rst(rst),
    .target_sel(tgt_r),
    .restart(ctrl_wr), // RULE10
    .step(cal_acc),
    .ptr(ptr),
    .last(last)
  );

  // control fields are latched on every control write, calibration starts included
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tgt_r <= 2'b00;
      rdb_r <= 2'b00;
      kind_r <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      tgt_r <= link.wdata[POS_TGT_HI:POS_TGT_LO]; // RULE3
      rdb_r <= link.wdata[POS_RDB_HI:POS_RDB_LO];
      kind_r <= link.wdata[POS_KIND];
    end
  end

  // conversion start from control bit or rising edge of the trigger pin
  // edge register resets to the pin's idle high level, so leaving reset is no edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trig_d_r <= 1'b1;
      conv_r <= 1'b0;
    end
    else
    begin
      trig_d_r <= link.conversion_trigger_n;
      conv_r <= (ctrl_wr && link.wdata[POS_CONV]) || (link.conversion_trigger_n && !trig_d_r); // RULE19
    end
  end

  // calibration sequencer, order fixed by the target select
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cal_st_r <= CAL_IDLE;
      cal_cnt_r <= 8'h00;
      dac_idx_r <= 4'h0;
    end
    else
    begin
      case (cal_st_r)
        CAL_IDLE:
        begin
          cal_cnt_r <= 8'h00;
          dac_idx_r <= 4'h0;
          if (ctrl_wr && link.wdata[POS_STCAL])
          begin
            case (link.wdata[POS_TGT_HI:POS_TGT_LO])
              TGT_ALL: cal_st_r <= CAL_DAC; // RULE21
              TGT_GAIN_OFS: cal_st_r <= CAL_GAIN;
              TGT_OFS: cal_st_r <= CAL_OFFSET;
              default: cal_st_r <= CAL_GAIN;
            endcase
          end
        end
        CAL_DAC:
        begin
          cal_cnt_r <= step_done ? 8'h00 : cal_cnt_r + 8'h01;
          if (step_done)
          begin
            dac_idx_r <= dac_idx_r + 4'h1;
            if (dac_idx_r == 4'(NUM_DAC - 1))
              cal_st_r <= CAL_GAIN; // RULE21
          end
        end
        CAL_GAIN:
        begin
          cal_cnt_r <= step_done ? 8'h00 : cal_cnt_r + 8'h01;
          if (step_done)
            cal_st_r <= (tgt_r == TGT_GAIN) ? CAL_IDLE : CAL_OFFSET; // RULE21
        end
        CAL_OFFSET:
        begin
          cal_cnt_r <= step_done ? 8'h00 : cal_cnt_r + 8'h01;
          if (step_done)
            cal_st_r <= CAL_IDLE;
        end
        default: cal_st_r <= CAL_IDLE;
      endcase
    end
  end

  // trim bank: host writes through the pointer, calibration writes measured values
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      trim_r[IDX_GAIN] <= GAIN_NOMINAL;
      trim_r[IDX_OFFSET] <= OFFSET_NOMINAL; // RULE14
      for (int i = 0; i < NUM_DAC; i++)
        trim_r[IDX_DAC0 + PTR_W'(i)] <= DAC_NOMINAL;
    end
    else if (cal_st_r != CAL_IDLE && step_done)
    begin
      case (cal_st_r)
        CAL_DAC: trim_r[IDX_DAC0 + dac_idx_r] <= dac_measured; // RULE2
        CAL_GAIN: trim_r[IDX_GAIN] <= gain_measured; // RULE2
        default: trim_r[IDX_OFFSET] <= offset_measured; // RULE2
      endcase
    end
    else if (cal_acc && link.op == OP_WRITE)
      trim_r[ptr] <= link.wdata[DATA_W-1:0]; // RULE13 RULE17
  end

  // every request is acknowledged, refused ones too, so the host never waits on a busy bank
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      rdata_r <= 16'h0000;
    end
    else
    begin
      ack_r <= link.req;
      if (cal_acc && link.op == OP_READ)
        rdata_r <= {2'b00, trim_r[ptr]}; // RULE11
    end
  end

  assign link.ack = ack_r;
  assign link.rdata = rdata_r;
  assign link.busy = cal_st_r != CAL_IDLE;
  assign conv_start = conv_r;
  assign cal_kind = kind_r;
  // analog side: bigger offset word lifts code, bigger gain word widens scale
  assign offset_trim = trim_r[IDX_OFFSET]; // RULE15 RULE16
  assign gain_trim = trim_r[IDX_GAIN]; // RULE18
endmodule

// file: verilog/cal_host.sv
// host end: drives master clock, control writes and calibration word sequences
`timescale 1ns/1ns
module cal_host (
  input wire logic clk,
  input wire logic rst,
  cal_if.host link,
  input wire logic cmd_valid,
  input wire cal_pkg::op_type cmd_op,
  input wire logic [15:0] cmd_data,
  input wire logic conv_pulse,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data
);
  import cal_pkg::*;

  logic [7:0] div_r;
  logic mclk_r;
  logic pend_r;
  op_type op_r;
  logic [15:0] data_r;
  logic rsp_v_r;
  logic [15:0] rsp_d_r;
  logic trig_r;

  // master clock derived from the system clock
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= 8'h00;
      mclk_r <= 1'b0;
    end
    else if (div_r == 8'(MCLK_DIV - 1))
    begin
      div_r <= 8'h00;
      mclk_r <= !mclk_r; // RULE20
    end
    else
      div_r <= div_r + 8'h01;
  end

  // one request outstanding; caller issues control write first
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pend_r <= 1'b0;
      op_r <= OP_NONE;
      data_r <= 16'h0000;
    end
    else if (!pend_r && cmd_valid)
    begin
      pend_r <= 1'b1;
      op_r <= cmd_op; // RULE5 RULE6 RULE12
      data_r <= cmd_data;
    end
    else if (pend_r)
      pend_r <= 1'b0; // RULE4
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rsp_v_r <= 1'b0;
      rsp_d_r <= 16'h0000;
      trig_r <= 1'b1;
    end
    else
    begin
      rsp_v_r <= link.ack && op_r == OP_READ;
      if (link.ack && op_r == OP_READ)
        rsp_d_r <= link.rdata;
      trig_r <= !conv_pulse;
    end
  end

  assign link.master_clock_input = mclk_r;
  assign link.conversion_trigger_n = trig_r;
  assign link.req = pend_r;
  assign link.op = op_r;
  assign link.wdata = data_r;
  assign cmd_ready = !pend_r;
  assign rsp_valid = rsp_v_r;
  assign rsp_data = rsp_d_r;
endmodule

// file: verilog/cal_ptr_seq.sv
// calibration register pointer: reset, first entry and stepping per target select
`timescale 1ns/1ns
module cal_ptr_seq (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] target_sel,
  input wire logic restart,
  input wire logic step,
  output logic [cal_pkg::PTR_W-1:0] ptr,
  output logic last
);
  import cal_pkg::*;

  function automatic logic [PTR_W-1:0] first_of(input logic [1:0] sel);
    first_of = (sel == TGT_OFS) ? IDX_OFFSET : IDX_GAIN; // RULE8
  endfunction

  function automatic logic [PTR_W-1:0] count_of(input logic [1:0] sel);
    case (sel)
      TGT_ALL: count_of = PTR_W'(NUM_REGS);
      TGT_GAIN_OFS: count_of = 4'h2;
      default: count_of = 4'h1;
    endcase
  endfunction

  logic [PTR_W-1:0] pos_r;

  assign ptr = first_of(target_sel) + pos_r; // RULE22
  assign last = (pos_r == count_of(target_sel) - 4'h1);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pos_r <= 4'h0;
    else if (restart)
      pos_r <= 4'h0; // RULE7
    else if (step)
    begin
      if (last)
        pos_r <= 4'h0; // RULE7
      else
        pos_r <= pos_r + 4'h1; // RULE9
    end
  end
endmodule
